// File: design/ofcr_readback.sv
// Read port of the configuration bank: picks one byte by command code.
// Assumes the serial engine presents a one-cycle read strobe.
`include "ofcr_map.svh"

module ofcr_readback (
  input  wire logic               sys_clk,
  input  wire logic               rst,
  input  wire logic               rd_req,
  input  wire ofcr_pkg::ofcr_byte_t rd_cmd,
  input  wire ofcr_pkg::ofcr_byte_t byte0,
  input  wire ofcr_pkg::ofcr_byte_t byte1,
  input  wire ofcr_pkg::ofcr_byte_t byte2,
  input  wire ofcr_pkg::ofcr_byte_t byte3,
  input  wire ofcr_pkg::ofcr_byte_t byte4,
  input  wire ofcr_pkg::ofcr_byte_t byte5,
  input  wire ofcr_pkg::ofcr_byte_t byte6,
  output ofcr_pkg::ofcr_byte_t    rd_data,
  output logic                    rd_valid
);

  ofcr_pkg::ofcr_byte_t next_rd_data;

  // Byte selection; unmapped codes return zero rather than aliasing
  always_comb begin
    case (rd_cmd)
      `OFCR_CMD_OUTPUT_ENABLE_LOW:   next_rd_data = byte0;
      `OFCR_CMD_OUTPUT_ENABLE_HIGH:  next_rd_data = byte1;
      `OFCR_CMD_RESERVED_BYTE:       next_rd_data = byte2;
      `OFCR_CMD_SLEW_SELECT_LOW:     next_rd_data = byte3;
      `OFCR_CMD_SLEW_HIGH_AND_SWING: next_rd_data = byte4;
      `OFCR_CMD_REVISION_AND_VENDOR: next_rd_data = byte5;
      `OFCR_CMD_FACTORY_CONFIG:      next_rd_data = byte6;
      default:                       next_rd_data = 8'h00;
    endcase
  end

  // Data is held between reads so a slow serializer can shift it out
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      rd_data <= 8'h00;
    end else if (rd_req) begin
      rd_data <= next_rd_data;
    end
  end

  // One-cycle marker that fresh data stands on rd_data
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      rd_valid <= 1'b0;
    end else begin
      rd_valid <= rd_req;
    end
  end

endmodule

// File: design/ofcr_regs.sv
// Configuration register bank of the eight-output clock fanout buffer.
// Assumes a serial bus engine outside decodes address, command code and
// data, and hands this bank one-cycle write and read strobes.
`include "ofcr_map.svh"

module ofcr_regs #(
  parameter ofcr_pkg::ofcr_nibble_t REV_CODE   = 4'h3, // Arbitrary value
  parameter ofcr_pkg::ofcr_nibble_t MAKER_CODE = 4'h5  // Arbitrary value
) (
  input  wire logic                 sys_clk,
  input  wire logic                 rst,
  input  wire logic                 reg_wr,
  input  wire logic                 reg_rd,
  input  wire ofcr_pkg::ofcr_byte_t reg_cmd,
  input  wire ofcr_pkg::ofcr_byte_t reg_wdata,
  output ofcr_pkg::ofcr_byte_t      reg_rdata,
  output logic                      reg_rvalid,
  output logic                      out0_enable,
  output logic                      out1_enable,
  output logic                      out2_enable,
  output logic                      out3_enable,
  output logic                      out4_enable,
  output logic                      out5_enable,
  output logic                      out6_enable,
  output logic                      out7_enable,
  output logic                      out0_edge_fast,
  output logic                      out1_edge_fast,
  output logic                      out2_edge_fast,
  output logic                      out3_edge_fast,
  output logic                      out4_edge_fast,
  output logic                      out5_edge_fast,
  output logic                      out6_edge_fast,
  output logic                      out7_edge_fast,
  output ofcr_pkg::ofcr_nibble_t    swing_level_code
);

  // Bit positions of each output within the {high, low} register pair
  localparam int OUT_POS [8] = '{`OFCR_POS_OUT0, `OFCR_POS_OUT1,
                                 `OFCR_POS_OUT2, `OFCR_POS_OUT3,
                                 `OFCR_POS_OUT4, `OFCR_POS_OUT5,
                                 `OFCR_POS_OUT6, `OFCR_POS_OUT7};

  // Register map as the host sees it, by command code:
  //   00  output enables, low   bits 6,5 -> outputs 4,3; bits 2:0 -> 2:0
  //   01  output enables, high  bits 7,6,4 -> outputs 7,6,5
  //   02  reserved, reads zero, writes dropped
  //   03  slew selects, low     same bit layout as code 00
  //   04  slew selects, high    bits 7,6,4; bits 3:0 swing level code
  //   05  revision nibble over maker nibble, read-only
  //   06  factory configuration byte, read-only, zero
  //   07 and above decode to nothing and read back as zero
  //
  // Reserved enable bits hold zero and reserved slew bits hold one, so a
  // read-modify-write from the host can never flip them by accident.
  //
  // Swing codes 6..b span 600 mV..850 mV in 50 mV steps; the reset code
  // 8 sits at 700 mV. Codes outside that span are refused; the slew bits of that write still land.
  //
  // Reads: data and its valid marker land one edge after the strobe. A
  // write and a read of one byte in the same cycle return the old value,
  // since the read mux samples the registers before the write lands.

  ofcr_pkg::ofcr_byte_t   output_enable_low;
  ofcr_pkg::ofcr_byte_t   output_enable_high;
  ofcr_pkg::ofcr_byte_t   slew_select_low;
  ofcr_pkg::ofcr_byte_t   slew_select_high_and_amplitude;
  logic [3:0]             slew_high_bits;
  ofcr_pkg::ofcr_nibble_t swing_code;
  ofcr_pkg::ofcr_byte_t   reserved_byte;
  ofcr_pkg::ofcr_byte_t   revision_and_vendor;
  ofcr_pkg::ofcr_byte_t   programming_identifier;
  logic [15:0]            enable_pair;
  logic [15:0]            slew_pair;
  ofcr_pkg::ofcr_out_t    enable_vec;
  ofcr_pkg::ofcr_out_t    edge_fast_vec;
  ofcr_pkg::ofcr_nibble_t wr_swing;
  logic                   swing_legal;
  logic                   wr_low_en;
  logic                   wr_high_en;
  logic                   wr_low_slew;
  logic                   wr_high_slew;

  // Write decode; each strobe lasts the one cycle that reg_wr does
  assign wr_low_en    = reg_wr && (reg_cmd == `OFCR_CMD_OUTPUT_ENABLE_LOW);
  assign wr_high_en   = reg_wr && (reg_cmd == `OFCR_CMD_OUTPUT_ENABLE_HIGH);
  assign wr_low_slew  = reg_wr && (reg_cmd == `OFCR_CMD_SLEW_SELECT_LOW);
  assign wr_high_slew = reg_wr && (reg_cmd == `OFCR_CMD_SLEW_HIGH_AND_SWING);

  // Swing code from the write byte, checked against the legal range
  assign wr_swing    = reg_wdata[`OFCR_SWING_MSB:`OFCR_SWING_LSB];
  assign swing_legal = (wr_swing >= `OFCR_SWING_MIN) &&
                       (wr_swing <= `OFCR_SWING_MAX);

  // Low enable byte; masked so reserved bits keep their zero default
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      output_enable_low <= `OFCR_RST_OUTPUT_ENABLE_LOW;
    end else if (wr_low_en) begin
      output_enable_low <=
        (reg_wdata & `OFCR_WMASK_OUTPUT_ENABLE_LOW) |
        (`OFCR_RST_OUTPUT_ENABLE_LOW & ~`OFCR_WMASK_OUTPUT_ENABLE_LOW);
    end
  end

  // High enable byte; bits 5 and 3:0 stay reserved at zero
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      output_enable_high <= `OFCR_RST_OUTPUT_ENABLE_HIGH;
    end else if (wr_high_en) begin
      output_enable_high <=
        (reg_wdata & `OFCR_WMASK_OUTPUT_ENABLE_HIGH) |
        (`OFCR_RST_OUTPUT_ENABLE_HIGH & ~`OFCR_WMASK_OUTPUT_ENABLE_HIGH);
    end
  end

  // Low slew byte; reserved bits are pinned at their default of one
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      slew_select_low <= `OFCR_RST_SLEW_SELECT_LOW;
    end else if (wr_low_slew) begin
      slew_select_low <=
        (reg_wdata & `OFCR_WMASK_SLEW_SELECT_LOW) |
        (`OFCR_RST_SLEW_SELECT_LOW & ~`OFCR_WMASK_SLEW_SELECT_LOW);
    end
  end

  // High slew bits of byte 4; bit 5 is reserved and pinned at one.
  // Held in a nibble of its own so that each always_ff owns the whole
  // variable it writes.
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      slew_high_bits <= 4'(`OFCR_RST_SLEW_HIGH_AND_SWING >> 4);
    end else if (wr_high_slew) begin
      slew_high_bits <=
        (reg_wdata[7:4] & 4'(`OFCR_WMASK_SLEW_HIGH >> 4)) |
        (4'(`OFCR_RST_SLEW_HIGH_AND_SWING >> 4) &
         ~4'(`OFCR_WMASK_SLEW_HIGH >> 4));
    end
  end

  // Swing field; an illegal code is refused so the drivers never see
  // an uncharacterised level, while the slew half of the write lands
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      swing_code <= 4'(`OFCR_RST_SLEW_HIGH_AND_SWING);
    end else if (wr_high_slew && swing_legal) begin
      swing_code <= wr_swing;
    end
  end

  // Byte 4 as read back: slew nibble over swing nibble
  assign slew_select_high_and_amplitude = {slew_high_bits, swing_code};

  // Reserved and identity bytes are constants; writes cannot reach them
  assign reserved_byte          = `OFCR_RST_RESERVED_BYTE;
  assign programming_identifier = `OFCR_RST_FACTORY_CONFIG;
  assign revision_and_vendor    = {REV_CODE, MAKER_CODE};

  // Register pairs seen as one 16-bit word for per-output lookup
  assign enable_pair = {output_enable_high, output_enable_low};
  assign slew_pair   = {slew_select_high_and_amplitude, slew_select_low};

  // Per-output unpacking; pure wiring of flop bits, so no added delay
  for (genvar i = 0; i < 8; i++) begin : g_out
    assign enable_vec[i]    = enable_pair[OUT_POS[i]];
    assign edge_fast_vec[i] = slew_pair[OUT_POS[i]];
  end

  // Driver controls, each straight from its register bit
  assign out0_enable      = enable_vec[0];
  assign out1_enable      = enable_vec[1];
  assign out2_enable      = enable_vec[2];
  assign out3_enable      = enable_vec[3];
  assign out4_enable      = enable_vec[4];
  assign out5_enable      = enable_vec[5];
  assign out6_enable      = enable_vec[6];
  assign out7_enable      = enable_vec[7];

  // Slew selects; a one gives the fast edge on that output's driver
  assign out0_edge_fast   = edge_fast_vec[0];
  assign out1_edge_fast   = edge_fast_vec[1];
  assign out2_edge_fast   = edge_fast_vec[2];
  assign out3_edge_fast   = edge_fast_vec[3];
  assign out4_edge_fast   = edge_fast_vec[4];
  assign out5_edge_fast   = edge_fast_vec[5];
  assign out6_edge_fast   = edge_fast_vec[6];
  assign out7_edge_fast   = edge_fast_vec[7];
  assign swing_level_code =
    slew_select_high_and_amplitude[`OFCR_SWING_MSB:`OFCR_SWING_LSB];

  // Read port; reserved bits come back as held defaults
  ofcr_readback u_readback (
    .sys_clk  (sys_clk),
    .rst      (rst),
    .rd_req   (reg_rd),
    .rd_cmd   (reg_cmd),
    .byte0    (output_enable_low),
    .byte1    (output_enable_high),
    .byte2    (reserved_byte),
    .byte3    (slew_select_low),
    .byte4    (slew_select_high_and_amplitude),
    .byte5    (revision_and_vendor),
    .byte6    (programming_identifier),
    .rd_data  (reg_rdata),
    .rd_valid (reg_rvalid)
  );

endmodule

// File: dv/ofcr_host.sv
// Host-side stand-in: issues decoded byte writes and reads.
// Assumes the bench calls its tasks; strobes move on the falling edge.
module ofcr_host (
  input  wire logic                 sys_clk,
  output logic                      reg_wr,
  output logic                      reg_rd,
  output ofcr_pkg::ofcr_byte_t      reg_cmd,
  output ofcr_pkg::ofcr_byte_t      reg_wdata,
  input  wire ofcr_pkg::ofcr_byte_t reg_rdata,
  input  wire logic                 reg_rvalid
);
  timeunit 1ns;
  timeprecision 1ps;

  initial begin
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_cmd = 8'h00;
    reg_wdata = 8'h00;
  end

  // One byte per strobe; released lines show the inverse, not old data
  task automatic wr(input ofcr_pkg::ofcr_byte_t c,
                    input ofcr_pkg::ofcr_byte_t d);
    @(negedge sys_clk);
    reg_wr = 1'b1;
    reg_cmd = c;
    reg_wdata = d;
    @(negedge sys_clk);
    reg_wr = 1'b0;
    reg_cmd = ~c;
    reg_wdata = ~d;
  endtask

  // Command code then one returned byte, taken while valid stands;
  // the answer has a fixed one-cycle latency, so no wait loop is needed
  task automatic rd(input  ofcr_pkg::ofcr_byte_t c,
                    output ofcr_pkg::ofcr_byte_t d,
                    output logic                 ok);
    @(negedge sys_clk);
    reg_rd = 1'b1;
    reg_cmd = c;
    @(negedge sys_clk);
    reg_rd = 1'b0;
    reg_cmd = ~c;
    ok = (reg_rvalid === 1'b1);
    d = reg_rdata;
  endtask
endmodule

// File: dv/ofcr_regs_asserts.sv
// Port-level checks of the configuration bank, bound into its top.
// Assumes one clock and an asynchronous active-high reset.
module ofcr_regs_asserts #(
  parameter ofcr_pkg::ofcr_nibble_t REV_CODE   = 4'h3, // Arbitrary value
  parameter ofcr_pkg::ofcr_nibble_t MAKER_CODE = 4'h5  // Arbitrary value
) (
  input wire logic                   sys_clk,
  input wire logic                   rst,
  input wire logic                   reg_wr,
  input wire logic                   reg_rd,
  input wire ofcr_pkg::ofcr_byte_t   reg_cmd,
  input wire ofcr_pkg::ofcr_byte_t   reg_wdata,
  input wire ofcr_pkg::ofcr_byte_t   reg_rdata,
  input wire logic                   reg_rvalid,
  input wire logic                   out0_enable,
  input wire logic                   out1_enable,
  input wire logic                   out2_enable,
  input wire logic                   out3_enable,
  input wire logic                   out4_enable,
  input wire logic                   out5_enable,
  input wire logic                   out6_enable,
  input wire logic                   out7_enable,
  input wire logic                   out0_edge_fast,
  input wire logic                   out1_edge_fast,
  input wire logic                   out2_edge_fast,
  input wire logic                   out3_edge_fast,
  input wire logic                   out4_edge_fast,
  input wire logic                   out5_edge_fast,
  input wire logic                   out6_edge_fast,
  input wire logic                   out7_edge_fast,
  input wire ofcr_pkg::ofcr_nibble_t swing_level_code
);
  timeunit 1ns;
  timeprecision 1ps;

  ofcr_pkg::ofcr_byte_t wd_q;
  wire logic [7:0] en = {out7_enable, out6_enable, out5_enable,
    out4_enable, out3_enable, out2_enable, out1_enable, out0_enable};
  wire logic [7:0] fs = {out7_edge_fast, out6_edge_fast, out5_edge_fast,
    out4_edge_fast, out3_edge_fast, out2_edge_fast, out1_edge_fast,
    out0_edge_fast};
  // Bytes rebuilt from the control outputs, reserved bits at default
  wire logic [7:0] b0 = {1'b0, en[4:3], 2'b00, en[2:0]};
  wire logic [7:0] b1 = {en[7:6], 1'b0, en[5], 4'h0};
  wire logic [7:0] b3 = {1'b1, fs[4:3], 2'b11, fs[2:0]};
  wire logic       wr_ctl = reg_wr && reg_cmd inside {[0:1], [3:4]};
  wire logic       sw_ok = reg_wdata[3:0] inside {[4'h6:4'hb]};

  // Write byte of the previous edge, for checks one cycle on
  always_ff @(posedge sys_clk) begin
    wd_q <= reg_wdata;
  end

  default clocking @(posedge sys_clk); endclocking
  default disable iff (rst);

  rd_answer_a: assert property (
    reg_rd |=> reg_rvalid)
    else $error("read strobe got no valid pulse");
  rd_single_a: assert property (
    !reg_rd |=> !reg_rvalid && $stable(reg_rdata))
    else $error("read output moved without a read");
  en_low_a: assert property (
    reg_wr && reg_cmd == 8'h00 |=> b0 == (wd_q & 8'h67))
    else $error("low enable byte not applied");
  en_high_a: assert property (
    reg_wr && reg_cmd == 8'h01 |=> b1 == (wd_q & 8'hd0))
    else $error("high enable byte not applied");
  slew_low_a: assert property (
    reg_wr && reg_cmd == 8'h03 |=> b3 == (wd_q | 8'h98))
    else $error("low slew byte not applied");
  slew_high_a: assert property (
    reg_wr && reg_cmd == 8'h04 |=>
      {fs[7:6], 1'b1, fs[5]} == (wd_q[7:4] | 4'h2))
    else $error("high slew bits not applied");
  swing_set_a: assert property (
    reg_wr && reg_cmd == 8'h04 && sw_ok |=> swing_level_code == wd_q[3:0])
    else $error("legal swing code not applied");
  swing_keep_a: assert property (
    reg_wr && reg_cmd == 8'h04 && !sw_ok |=> $stable(swing_level_code))
    else $error("illegal swing code was applied");
  ctl_hold_a: assert property (
    !wr_ctl |=> $stable({en, fs, swing_level_code}))
    else $error("controls moved without a write");
  id_read_a: assert property (
    reg_rd && reg_cmd == 8'h05 |=> reg_rdata == {REV_CODE, MAKER_CODE})
    else $error("identity byte wrong");
  zero_read_a: assert property (
    reg_rd && reg_cmd inside {8'h02, [8'h06:8'hff]} |=> reg_rdata == 8'h00)
    else $error("reserved or programming byte not zero");
endmodule

bind ofcr_regs ofcr_regs_asserts #(
  .REV_CODE   (REV_CODE),
  .MAKER_CODE (MAKER_CODE)
) chk_i (.*);

// File: dv/ofcr_regs_tb.sv
// Self-checking bench of the configuration bank.
// Assumes the host model and the bound checker are compiled alongside.
module ofcr_regs_tb;
  timeunit 1ns;
  timeprecision 1ps;
  localparam ofcr_pkg::ofcr_nibble_t REV = 4'h3; // Arbitrary value
  localparam ofcr_pkg::ofcr_nibble_t MAK = 4'h5; // Arbitrary value
  logic sys_clk, rst, reg_wr, reg_rd, reg_rvalid;
  ofcr_pkg::ofcr_byte_t reg_cmd, reg_wdata, reg_rdata;
  logic out0_enable, out1_enable, out2_enable, out3_enable;
  logic out4_enable, out5_enable, out6_enable, out7_enable;
  logic out0_edge_fast, out1_edge_fast, out2_edge_fast, out3_edge_fast;
  logic out4_edge_fast, out5_edge_fast, out6_edge_fast, out7_edge_fast;
  ofcr_pkg::ofcr_nibble_t swing_level_code;
  int fails = 0;
  int compares = 0;
  wire logic [7:0] en = {out7_enable, out6_enable, out5_enable,
    out4_enable, out3_enable, out2_enable, out1_enable, out0_enable};
  wire logic [7:0] fs = {out7_edge_fast, out6_edge_fast, out5_edge_fast,
    out4_edge_fast, out3_edge_fast, out2_edge_fast, out1_edge_fast,
    out0_edge_fast};

  ofcr_regs #(.REV_CODE(REV), .MAKER_CODE(MAK)) dut (.*);
  ofcr_host host (.*);

  initial begin
    sys_clk = 1'b0;
    forever #20 sys_clk = ~sys_clk;
  end

  task automatic stop_test();
    $display("fails=%0d compares=%0d", fails, compares);
    if (fails == 0 && compares > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask

  task automatic chk(input ofcr_pkg::ofcr_byte_t got,
                     input ofcr_pkg::ofcr_byte_t exp);
    compares++;
    if (got !== exp) begin
      fails++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // Read by command code; a missing valid pulse ends the run
  task automatic rchk(input ofcr_pkg::ofcr_byte_t c,
                      input ofcr_pkg::ofcr_byte_t exp);
    ofcr_pkg::ofcr_byte_t d;
    logic ok;
    host.rd(c, d, ok);
    if (ok !== 1'b1) begin
      fails++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, 8'h00, 8'h01);
      stop_test();
    end else begin
      chk(d, exp);
    end
  endtask

  task automatic t_reset();
    ofcr_pkg::ofcr_byte_t rv [7] = '{8'h67, 8'hd0, 8'h00, 8'hff, 8'hf8,
                                     {REV, MAK}, 8'h00};
    for (int i = 0; i < 7; i++) begin
      rchk(8'(i), rv[i]);
    end
    chk(en, 8'hff);
    chk(fs, 8'hff);
    chk({4'h0, swing_level_code}, 8'h08);
  endtask

  // Zeros, ones and single bits expose a swapped output position
  task automatic t_enable();
    host.wr(8'h00, 8'h00);
    chk(en, 8'he0);
    host.wr(8'h01, 8'h00);
    chk(en, 8'h00);
    host.wr(8'h00, 8'hff);
    rchk(8'h00, 8'h67);
    host.wr(8'h01, 8'hff);
    rchk(8'h01, 8'hd0);
    host.wr(8'h00, 8'h20);
    chk(en, 8'he8);
    host.wr(8'h01, 8'h10);
    chk(en, 8'h28);
  endtask

  // Swing codes just outside the legal range must be refused
  task automatic t_slew();
    ofcr_pkg::ofcr_nibble_t keep = 4'h6; // Left by the 8'h16 write below
    host.wr(8'h03, 8'h40);
    chk(fs, 8'hf0);
    rchk(8'h03, 8'hd8);
    host.wr(8'h04, 8'h16);
    chk(fs, 8'h30);
    rchk(8'h04, 8'h36);
    for (int c = 5; c < 13; c++) begin
      host.wr(8'h04, {4'hf, 4'(c)});
      if (c > 5 && c < 12) keep = 4'(c);
      chk({4'h0, swing_level_code}, {4'h0, keep});
    end
  endtask

  // Writes to read-only and unmapped codes leave everything alone
  task automatic t_ro();
    ofcr_pkg::ofcr_byte_t cs [4] = '{8'h02, 8'h05, 8'h06, 8'h07};
    ofcr_pkg::ofcr_byte_t ex [4] = '{8'h00, {REV, MAK}, 8'h00, 8'h00};
    for (int i = 0; i < 4; i++) host.wr(cs[i], 8'hff);
    for (int i = 0; i < 4; i++) rchk(cs[i], ex[i]);
    chk(en, 8'h28);
    rst = 1'b1;
    repeat (2) @(negedge sys_clk);
    rst = 1'b0;
    chk(en, 8'hff);
    chk(fs, 8'hff);
    chk({4'h0, swing_level_code}, 8'h08);
    rchk(8'h04, 8'hf8);
  endtask

  initial begin
    rst = 1'b1;
    repeat (12) @(negedge sys_clk);
    rst = 1'b0;
    t_reset();
    t_enable();
    t_slew();
    t_ro();
    stop_test();
  end
endmodule

// File: pkg/ofcr_map.svh
// Command codes, field positions and reset values of the output fanout
// configuration bank. Included by bare name; definitions only.
`ifndef OFCR_MAP_SVH
`define OFCR_MAP_SVH

// Command codes naming each byte register
`define OFCR_CMD_OUTPUT_ENABLE_LOW     8'h00
`define OFCR_CMD_OUTPUT_ENABLE_HIGH    8'h01
`define OFCR_CMD_RESERVED_BYTE         8'h02
`define OFCR_CMD_SLEW_SELECT_LOW       8'h03
`define OFCR_CMD_SLEW_HIGH_AND_SWING   8'h04
`define OFCR_CMD_REVISION_AND_VENDOR   8'h05
`define OFCR_CMD_FACTORY_CONFIG        8'h06
`define OFCR_REG_COUNT                 7

// Reset values of each byte except byte 5, which is built from parameters
`define OFCR_RST_OUTPUT_ENABLE_LOW     8'h67
`define OFCR_RST_OUTPUT_ENABLE_HIGH    8'hd0
`define OFCR_RST_RESERVED_BYTE         8'h00
`define OFCR_RST_SLEW_SELECT_LOW       8'hff
`define OFCR_RST_SLEW_HIGH_AND_SWING   8'hf8
`define OFCR_RST_FACTORY_CONFIG        8'h00

// Bits that software may change; all other bits hold their reset value, except the swing field of byte 4, which writes of a legal code change
`define OFCR_WMASK_OUTPUT_ENABLE_LOW   8'h67
`define OFCR_WMASK_OUTPUT_ENABLE_HIGH  8'hd0
`define OFCR_WMASK_SLEW_SELECT_LOW     8'h67
`define OFCR_WMASK_SLEW_HIGH           8'hd0

// Positions of the per-output bits in the 16-bit pair {high, low}
`define OFCR_POS_OUT0                  0
`define OFCR_POS_OUT1                  1
`define OFCR_POS_OUT2                  2
`define OFCR_POS_OUT3                  5
`define OFCR_POS_OUT4                  6
`define OFCR_POS_OUT5                  12
`define OFCR_POS_OUT6                  14
`define OFCR_POS_OUT7                  15

// Swing level code field in byte 4 and its legal range
`define OFCR_SWING_MSB                 3
`define OFCR_SWING_LSB                 0
`define OFCR_SWING_MIN                 4'h6
`define OFCR_SWING_MAX                 4'hb

// Revision and maker nibbles in byte 5
`define OFCR_REV_MSB                   7
`define OFCR_REV_LSB                   4
`define OFCR_MAKER_MSB                 3
`define OFCR_MAKER_LSB                 0

`endif

// File: pkg/ofcr_pkg.sv
// Types shared by the output fanout configuration bank.
// Assumes the map header carries all numbers.
package ofcr_pkg;

  typedef logic [7:0] ofcr_byte_t;
  typedef logic [3:0] ofcr_nibble_t;
  typedef logic [7:0] ofcr_out_t;

endpackage
